// ===== hw/global_config_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "glob_regs_cfg.svh"
module global_config_status_regs
  import glob_regs_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE = `PV_VERSION_DEFAULT // Arbitrary value
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_spi_sck,
  input  wire logic              i_spi_cs_b,
  input  wire logic              i_spi_mosi,
  output logic                   o_spi_miso,
  output logic                   o_spi_miso_oe,
  input  wire logic              i_drv_disable_b,
  input  wire logic              i_driver_a_fault,
  input  wire logic              i_driver_b_fault,
  input  wire logic              i_pump_undervoltage,
  input  wire logic [31:0]       i_current_position,
  input  wire logic              i_event,
  input  wire logic              i_motor_a_dir,
  input  wire logic              i_motor_b_dir,
  input  wire logic [4:0]        i_probe_src,
  output logic                   o_motor_a_dir,
  output logic                   o_motor_b_dir,
  output logic                   o_driver_enable,
  output logic                   o_event_out,
  output logic                   o_event_out_oe,
  output logic                   o_position_pulse_out,
  output logic                   o_position_pulse_out_oe,
  output logic                   o_right_switch_b_pin,
  output logic                   o_right_switch_b_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial port

  logic [3:0]             pins_s;
  logic [2:0]             spi_s;
  logic                   frame_valid;
  logic [7:0]             frame_addr;
  reg_word_t              frame_data;
  logic [`FRAME_BITS-1:0] tx_word;

  pin_sync2 #(.WIDTH(4)) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({i_pump_undervoltage, i_driver_b_fault,
                  i_driver_a_fault, i_drv_disable_b}),
    .o_sync     (pins_s)
  );

  // Select and clock pass inverted so that flop reset equals idle level
  pin_sync2 #(.WIDTH(3)) u_spi_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({i_spi_mosi, ~i_spi_cs_b, ~i_spi_sck}),
    .o_sync     (spi_s)
  );

  spi_frame_port u_spi (
    .i_core_clk    (i_core_clk),
    .i_rst_b       (i_rst_b),
    .i_sck_s       (~spi_s[0]),
    .i_cs_b_s      (~spi_s[1]),
    .i_mosi_s      (spi_s[2]),
    .i_tx_word     (tx_word),
    .o_miso        (o_spi_miso),
    .o_frame_valid (frame_valid),
    .o_frame_addr  (frame_addr),
    .o_frame_data  (frame_data)
  );

  // Data line driven only while selected
  assign o_spi_miso_oe = spi_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic       disable_pin_s;
  logic       drv_a_s;
  logic       drv_b_s;
  logic       pump_uv_s;
  logic       is_write;
  reg_index_t index;
  logic       wr_settings;
  logic       rd_flags;

  assign disable_pin_s = pins_s[0];
  assign drv_a_s       = pins_s[1];
  assign drv_b_s       = pins_s[2];
  assign pump_uv_s     = pins_s[3];
  assign is_write      = frame_addr[`ADDR_WRITE_BIT];
  assign index         = frame_addr[6:0];
  assign rd_flags      = frame_valid & ~is_write
                         & (index == `ADDR_GLOBAL_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [`GS_WIDTH-1:0] settings_q;
  logic [`PS_WIDTH-1:0] probe_sel_q;
  reg_word_t            match_q;

  assign wr_settings = frame_valid & is_write
                       & (index == `ADDR_GLOBAL_SETTINGS)
                       & ~settings_q[`GS_FREEZE_BIT];

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      settings_q <= `GS_RESET;
    end else if (wr_settings) begin
      settings_q <= frame_data[`GS_WIDTH-1:0] & `GS_WRITABLE_MASK;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      probe_sel_q <= `PS_RESET;
    end else if (frame_valid & is_write & (index == `ADDR_PROBE_SELECT)) begin
      probe_sel_q <= frame_data[`PS_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_q <= `PM_RESET;
    end else if (frame_valid & is_write & (index == `ADDR_POS_MATCH)) begin
      match_q <= frame_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over the clear of a read

  logic [`GF_WIDTH-1:0] flags_q;
  logic [`GF_WIDTH-1:0] flags_set;

  assign flags_set = {pump_uv_s, drv_b_s, drv_a_s, 1'b0};

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= `GF_RESET;
    end else if (rd_flags) begin
      flags_q <= flags_set;
    end else begin
      flags_q <= flags_q | flags_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data of a read returns in the next datagram

  reg_word_t read_q;
  reg_word_t read_mux;

  always_comb begin
    read_mux = '0;
    case (index)
      `ADDR_GLOBAL_SETTINGS: read_mux = {21'h0, settings_q};
      `ADDR_GLOBAL_FLAGS:    read_mux = {28'h0, flags_q};
      `ADDR_PIN_AND_VERSION: begin
        read_mux[`PV_VERSION_LSB +: 8]   = VERSION_CODE;
        read_mux[`PV_DISABLE_PIN_BIT]    = disable_pin_s;
      end
      default:               read_mux = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      read_q <= '0;
    end else if (frame_valid & ~is_write) begin
      read_q <= read_mux;
    end
  end

  // Status byte leads every reply
  assign tx_word = {4'h0, flags_q, read_q};

  ////////////////////////////////////////////////////////////////////////////
  // Pin side outputs

  logic       pulse_q;
  logic       event_q;
  logic       probe_bit;
  logic       poscmp_en;
  logic [4:0] probe_onehot;

  assign poscmp_en = settings_q[`GS_POSCMP_EN_BIT];

  // One select line per test source
  for (genvar g = 0; g < `PS_SOURCES; g++) begin : g_probe
    assign probe_onehot[g] = (probe_sel_q == `PS_WIDTH'(g)) & i_probe_src[g];
  end
  assign probe_bit = |probe_onehot;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      pulse_q <= (i_current_position == match_q);
      event_q <= i_event;
    end
  end

  assign o_position_pulse_out    = pulse_q;
  assign o_position_pulse_out_oe = poscmp_en;
  assign o_event_out             = event_q;
  assign o_event_out_oe          = poscmp_en;

  assign o_right_switch_b_pin    = probe_bit;
  assign o_right_switch_b_pin_oe = settings_q[`GS_TEST_MODE_BIT];

  assign o_motor_a_dir = i_motor_a_dir ^ settings_q[`GS_MOTOR_A_INV_BIT];
  assign o_motor_b_dir = i_motor_b_dir ^ settings_q[`GS_MOTOR_B_INV_BIT];
  assign o_driver_enable = ~pump_uv_s;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_freeze_holds:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $past(settings_q[`GS_FREEZE_BIT]) |-> $stable(settings_q))
    else $error("settings changed while frozen");

  a_reset_flag_hold:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      flags_q[`GF_RESET_BIT] && !rd_flags |=> flags_q[`GF_RESET_BIT])
    else $error("reset flag lost without read");

  a_fault_a_sticky:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      drv_a_s |=> flags_q[`GF_DRV_A_BIT])
    else $error("driver a fault not flagged");

  a_fault_b_sticky:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      drv_b_s |=> flags_q[`GF_DRV_B_BIT])
    else $error("driver b fault not flagged");

  a_read_clears_idle:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      rd_flags && !drv_a_s && !drv_b_s |=>
        !flags_q[`GF_DRV_A_BIT] && !flags_q[`GF_DRV_B_BIT])
    else $error("fault flag kept after clearing read");

  a_uv_disables:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      pump_uv_s |-> !o_driver_enable ##1 flags_q[`GF_PUMP_UV_BIT])
    else $error("undervoltage not handled");

  a_pulse_match:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      ##1 o_position_pulse_out == $past(i_current_position == match_q))
    else $error("position pulse wrong");

  a_outputs_float:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_position_pulse_out_oe == o_event_out_oe
      && o_event_out_oe == settings_q[`GS_POSCMP_EN_BIT])
    else $error("compare outputs enable wrong");

  a_reserved_zero:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (settings_q & ~`GS_WRITABLE_MASK) == '0)
    else $error("reserved settings bit set");

  a_dir_invert:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      settings_q[`GS_MOTOR_A_INV_BIT] |-> o_motor_a_dir != i_motor_a_dir)
    else $error("motor a not inverted");

  a_dir_invert_b:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (o_motor_b_dir != i_motor_b_dir) == settings_q[`GS_MOTOR_B_INV_BIT])
    else $error("motor b direction wrong");

  a_test_route:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_right_switch_b_pin_oe == settings_q[`GS_TEST_MODE_BIT])
    else $error("test route enable wrong");

  a_probe_range:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      probe_sel_q >= `PS_WIDTH'(`PS_SOURCES) |-> !o_right_switch_b_pin)
    else $error("probe code above range drives pin");

  a_flag_cleared:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      rd_flags |=> !flags_q[`GF_RESET_BIT])
    else $error("reset flag kept after read");

  a_match_load:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      frame_valid && is_write && index == `ADDR_POS_MATCH |=>
        match_q == $past(frame_data))
    else $error("match value not stored");

  a_version_read:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      frame_valid && !is_write && index == `ADDR_PIN_AND_VERSION |=>
        read_q[`PV_VERSION_LSB +: 8] == VERSION_CODE)
    else $error("version code wrong");

  a_pin_level_read:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      frame_valid && !is_write && index == `ADDR_PIN_AND_VERSION |=>
        read_q[`PV_DISABLE_PIN_BIT] == $past(disable_pin_s))
    else $error("disable pin level wrong");

endmodule
`default_nettype wire

// ===== hw/glob_regs_cfg.svh
`ifndef GLOB_REGS_CFG_SVH
`define GLOB_REGS_CFG_SVH

// Register indices (seven-bit address, top bit of the byte is write)
`define ADDR_GLOBAL_SETTINGS  7'h00
`define ADDR_GLOBAL_FLAGS     7'h01
`define ADDR_PROBE_SELECT     7'h03
`define ADDR_PIN_AND_VERSION  7'h04
`define ADDR_POS_MATCH        7'h05
`define ADDR_WRITE_BIT        7

// global_settings fields
`define GS_POSCMP_EN_BIT      3
`define GS_TEST_MODE_BIT      7
`define GS_MOTOR_A_INV_BIT    8
`define GS_MOTOR_B_INV_BIT    9
`define GS_FREEZE_BIT         10
`define GS_WIDTH              11
`define GS_WRITABLE_MASK      11'h788
`define GS_RESET              11'h000

// global_flags fields
`define GF_RESET_BIT          0
`define GF_DRV_A_BIT          1
`define GF_DRV_B_BIT          2
`define GF_PUMP_UV_BIT        3
`define GF_WIDTH              4
`define GF_RESET              4'h1

// probe_source_select, pin_and_version and position match fields
`define PS_WIDTH              4
`define PS_RESET              4'h0
`define PS_SOURCES            5
`define PV_DISABLE_PIN_BIT    7
`define PV_VERSION_LSB        24
`define PV_VERSION_DEFAULT    8'hA5
`define PM_RESET              32'h0000_0000

// Serial datagram: address byte then 32 data bits
`define FRAME_BITS            40
`define FRAME_CNT_W           6

`endif

// ===== hw/glob_regs_pkg.sv
package glob_regs_pkg;

  typedef logic [6:0]  reg_index_t;
  typedef logic [31:0] reg_word_t;

  // Serial port sequencing, one-hot
  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b01,
    SPI_SHIFT = 2'b10
  } spi_state_t;

endpackage

// ===== hw/pin_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // Two flops per bit; the first is read only by the second
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        meta_q[g] <= 1'b0;
        o_sync[g] <= 1'b0;
      end else begin
        meta_q[g] <= i_async[g];
        o_sync[g] <= meta_q[g];
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/spi_frame_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "glob_regs_cfg.svh"
module spi_frame_port
  import glob_regs_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_sck_s,
  input  wire logic                   i_cs_b_s,
  input  wire logic                   i_mosi_s,
  input  wire logic [`FRAME_BITS-1:0] i_tx_word,
  output logic                        o_miso,
  output logic                        o_frame_valid,
  output logic [7:0]                  o_frame_addr,
  output reg_word_t                   o_frame_data
);

  spi_state_t               state_q;
  logic                     sck_prev_q;
  logic                     cs_prev_q;
  logic [`FRAME_BITS-1:0]   rx_q;
  logic [`FRAME_BITS-1:0]   tx_q;
  logic [`FRAME_CNT_W-1:0]  cnt_q;
  logic                     sck_rise;
  logic                     sck_fall;
  logic                     cs_fall;
  logic                     cs_rise;

  // Edges of the already synchronised pins
  assign sck_rise = i_sck_s & ~sck_prev_q;
  assign sck_fall = ~i_sck_s & sck_prev_q;
  assign cs_fall  = ~i_cs_b_s & cs_prev_q;
  assign cs_rise  = i_cs_b_s & ~cs_prev_q;
  assign o_miso       = tx_q[`FRAME_BITS-1];
  assign o_frame_addr = rx_q[`FRAME_BITS-1 -: 8];
  assign o_frame_data = rx_q[31:0];

  // Edge history
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_prev_q <= 1'b1;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= i_sck_s;
      cs_prev_q  <= i_cs_b_s;
    end
  end

  // Datagram sequencing; only a full 40-bit frame is accepted
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q       <= SPI_IDLE;
      rx_q          <= '0;
      tx_q          <= '0;
      cnt_q         <= '0;
      o_frame_valid <= 1'b0;
    end else begin
      o_frame_valid <= 1'b0;
      case (state_q)
        SPI_IDLE: begin
          if (cs_fall) begin
            state_q <= SPI_SHIFT;
            tx_q    <= i_tx_word;
            cnt_q   <= '0;
          end
        end
        SPI_SHIFT: begin
          if (cs_rise) begin
            state_q       <= SPI_IDLE;
            o_frame_valid <= (cnt_q == `FRAME_CNT_W'(`FRAME_BITS));
          end else if (sck_rise) begin
            rx_q <= {rx_q[`FRAME_BITS-2:0], i_mosi_s};
            if (cnt_q != '1) begin
              cnt_q <= cnt_q + `FRAME_CNT_W'(1);
            end
          end else if (sck_fall && (cnt_q != '0)) begin
            // First falling edge leaves the leading bit for the host
            tx_q <= {tx_q[`FRAME_BITS-2:0], 1'b0};
          end
        end
        default: begin
          state_q <= SPI_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_spi_miso,
  output logic             o_spi_sck,
  output logic             o_spi_cs_b,
  output logic             o_spi_mosi,
  output logic             o_rx_valid,
  output logic [39:0]      o_rx_word
);
  // Core cycles per serial clock phase, above the minimum of four
  localparam int HALF = 5;

  // Idle bus: select high, serial clock parked high
  initial begin
    o_spi_sck  = 1'b1;
    o_spi_cs_b = 1'b1;
    o_spi_mosi = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_word  = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 40-bit mode 3 frame, msb first, reply sampled at rising edges
  task automatic xfer(input logic [7:0] head, input logic [31:0] data);
    logic [39:0] tx;
    logic [39:0] rx;
    tx = {head, data};
    rx = '0;
    @(negedge i_core_clk);
    o_spi_cs_b = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      repeat (HALF) @(negedge i_core_clk);
      o_spi_sck  = 1'b0;
      o_spi_mosi = tx[i];
      repeat (HALF) @(negedge i_core_clk);
      rx[i]     = i_spi_miso;
      o_spi_sck = 1'b1;
    end
    repeat (HALF) @(negedge i_core_clk);
    o_spi_cs_b = 1'b1;
    o_spi_mosi = ~tx[0]; // Released line shows no stale bit
    o_rx_word  = rx;
    o_rx_valid = 1'b1;
    @(negedge i_core_clk);
    o_rx_valid = 1'b0;
    repeat (HALF) @(negedge i_core_clk);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    xfer({1'b1, idx}, d);
  endtask

  // Reads use the plain index
  task automatic rd(input logic [6:0] idx);
    xfer({1'b0, idx}, 32'h0000_0000);
  endtask
endmodule
`default_nettype wire

// ===== dv/global_config_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module global_config_status_regs_tb;
  localparam logic [7:0] VER = 8'h3C; // Arbitrary value

  logic        clk, rst_b, sck, cs_b, mosi, miso, miso_oe, dis_b;
  logic        flt_a, flt_b, uv, evt, dir_a, dir_b, dir_a_o, dir_b_o;
  logic        drv_en, evt_o, evt_oe, pulse, pulse_oe, rsb, rsb_oe, rx_v;
  logic [31:0] pos, m, pend_e, pend_m;
  logic [4:0]  src;
  logic [39:0] rx_w;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          num_errors, cmp_count, seed;

  // Core clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  global_config_status_regs #(.VERSION_CODE(VER)) dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_spi_sck(sck),
    .i_spi_cs_b(cs_b), .i_spi_mosi(mosi), .o_spi_miso(miso),
    .o_spi_miso_oe(miso_oe), .i_drv_disable_b(dis_b),
    .i_driver_a_fault(flt_a), .i_driver_b_fault(flt_b),
    .i_pump_undervoltage(uv), .i_current_position(pos), .i_event(evt),
    .i_motor_a_dir(dir_a), .i_motor_b_dir(dir_b), .i_probe_src(src),
    .o_motor_a_dir(dir_a_o), .o_motor_b_dir(dir_b_o),
    .o_driver_enable(drv_en), .o_event_out(evt_o),
    .o_event_out_oe(evt_oe), .o_position_pulse_out(pulse),
    .o_position_pulse_out_oe(pulse_oe), .o_right_switch_b_pin(rsb),
    .o_right_switch_b_pin_oe(rsb_oe)
  );

  spi_host_model host (
    .i_core_clk(clk), .i_spi_miso(miso), .o_spi_sck(sck),
    .o_spi_cs_b(cs_b), .o_spi_mosi(mosi), .o_rx_valid(rx_v),
    .o_rx_word(rx_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reply of each frame carries the read of the frame before
  task automatic xf(input logic w, input logic [6:0] idx,
                    input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] mk);
    exp_q.push_back(pend_e & pend_m);
    msk_q.push_back(pend_m);
    if (w) host.wr(idx, d);
    else host.rd(idx);
    pend_e = e;
    pend_m = w ? 32'h0000_0000 : mk;
  endtask

  task automatic reg_wr(input logic [6:0] idx, input logic [31:0] d);
    xf(1'b1, idx, d, 32'h0, 32'h0);
  endtask

  task automatic reg_rd(input logic [6:0] idx, input logic [31:0] e,
                        input logic [31:0] mk);
    xf(1'b0, idx, 32'h0, e, mk);
  endtask

  // Unmapped read, also pushes out the pending reply
  task automatic flush();
    reg_rd(7'h02, 32'h0, 32'hFFFF_FFFF);
  endtask

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b  = 1'b1;
    pend_m = '0;
    repeat (4) @(negedge clk);
  endtask

  // Reply monitor takes the oldest note at the end of each frame
  always @(posedge clk) begin
    if (rx_v === 1'b1 && exp_q.size() > 0) begin
      chk(rx_w[31:0] & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hFB4D;
    {rst_b, flt_a, flt_b, uv, evt, dir_a, dir_b} = '0;
    {num_errors, cmp_count} = '0;
    pend_e = '0;
    pend_m = '0;
    pos    = $random(seed);
    src    = '0;
    dis_b  = $random(seed);
    do_reset();
    chk(32'(miso_oe), 32'h0);
    reg_rd(7'h00, 32'h0, 32'hFFFF_FFFF);
    reg_rd(7'h01, 32'h1, 32'hF);
    reg_rd(7'h01, 32'h0, 32'hF);
    reg_rd(7'h04, {VER, 16'h0, dis_b, 7'h0}, 32'hFF00_0080);
    reg_wr(7'h00, 32'hFFFF_FBFF);
    reg_rd(7'h00, 32'h388, 32'hFFFF_FFFF);
    settle();
    chk(32'({evt_oe, pulse_oe, rsb_oe}), 32'h7);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      chk(32'(evt_o), 32'(evt));
      {evt, dir_a, dir_b} = $random(seed);
      #1 chk(32'({dir_a_o, dir_b_o}), 32'({~dir_a, ~dir_b}));
    end
    for (int c = 0; c < 6; c++) begin
      reg_wr(7'h03, 32'(c));
      src = $random(seed);
      settle();
      chk(32'(rsb), (c < 5) ? 32'(src[c]) : 32'h0);
    end
    reg_wr(7'h03, 32'h0);
    m = $random(seed);
    reg_wr(7'h05, m);
    settle();
    for (int k = 0; k < 6; k++) begin
      pos = (k % 2) ? m ^ (32'h1 << k) : m;
      @(negedge clk);
      chk(32'(pulse), 32'(k % 2 == 0));
    end
    flt_a = 1'b1;
    repeat (4) @(negedge clk);
    {flt_a, flt_b, uv} = 3'b011;
    settle();
    chk(32'(drv_en), 32'h0);
    reg_rd(7'h01, 32'hE, 32'hF);
    reg_rd(7'h01, 32'hC, 32'hF);
    {flt_b, uv} = 2'b00;
    settle();
    chk(32'(drv_en), 32'h1);
    reg_rd(7'h01, 32'hC, 32'hF);
    reg_rd(7'h01, 32'h0, 32'hF);
    reg_wr(7'h00, 32'h400);
    reg_wr(7'h00, 32'h388);
    reg_rd(7'h00, 32'h400, 32'hFFFF_FFFF);
    flush();
    chk(32'({evt_oe, pulse_oe, rsb_oe}), 32'h0);
    do_reset();
    reg_rd(7'h00, 32'h0, 32'hFFFF_FFFF);
    reg_rd(7'h01, 32'h1, 32'hF);
    flush();
    end_sim();
  end
endmodule
`default_nettype wire
